// ===== ctfaf_top.sv
// Purpose: tx flags, abort handshake, acceptance filter, error counters
// Assumes: rx/tx engine outside drives one-cycle event pulses
// Notes: APB slave, zero wait states, unmapped reads return zero
//
// Operation
// - bus-off/overrun enabled flags raise error irq
// - enabled receive full raises receive irq
// - enables, flags, control held reset in softreset
// - abort ack read-only; empty cleared by one
// - abort ack set on abort, cleared with empty
// - cpu clears empty; device sets on success
// - abort sets empty; empty set clears request
// - enabled empty flag keeps tx irq pending
// - abort granted only before start or failure
// - cpu sets abort request, never clears
// - mode selects 32/16/8 filters or closed
// - closed mode accepts nothing
// - hit index updated on foreground copy
// - filter control writable only in softreset
// - error counters read-only, read in sleep/reset; code returns them in any mode
// - rejected messages are dropped silently
// - code compares id bytes; std uses two
// - mask one ignores bit; all others match
// - code and mask writable only in softreset
// - accepted message sets receive full flag
//
// The implementer's own choices: the placing of the registers and register access over APB.
`timescale 1ns/1ns
module ctfaf_top (
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic busOffFlag,
	input wire logic overrunFlag,
	input wire logic rxDone,
	input wire logic [31:0] rxId,
	input wire logic rxExtended,
	input wire logic rxRelease,
	input wire logic [2:0] txSent,
	input wire logic [2:0] txIdle,
	input wire logic [2:0] txFailed,
	input wire logic [7:0] recCount,
	input wire logic [7:0] tecCount,
	output logic [2:0] txSchedule,
	output logic [2:0] abortPending,
	output logic softReset,
	output logic errIrq,
	output logic rxIrq,
	output logic txIrq
);
	typedef struct packed {
		logic [7:0] ctrl0;
		logic [7:0] rie;
		logic [2:0] tx_buffer_empty;
		logic [2:0] abort_acknowledge;
		logic [2:0] abort_request;
		logic [2:0] tx_empty_irq_enable;
		logic [2:0] mode;
		logic [2:0] hit;
		logic [31:0] code;
		logic [31:0] mask;
		logic rxFull;
		logic [31:0] rdata;
		logic ready;
		logic errIrq;
		logic rxIrq;
		logic txIrq;
	} ctfaf_state_type;

	ctfaf_state_type st;
	ctfaf_state_type next_st;
	logic [3:0] bankMatch;
	logic accepted;
	logic [2:0] hitIdx;
	logic access;
	logic wr;
	logic [2:0] grant;

	// ==========================================================
	// acceptance filter
	always_comb begin
		bankMatch = 4'h0;
		for (int i = 0; i < 4; i++) begin
			bankMatch[i] = &(~(rxId[8*i +: 8] ^ st.code[8*i +: 8])
				| st.mask[8*i +: 8]);
		end
	end

	always_comb begin
		accepted = 1'b0;
		hitIdx = 3'h0;
		case (st.mode)
			ctfaf_pkg::MODE_32: begin
				accepted = rxExtended ? &bankMatch : &bankMatch[1:0];
			end
			ctfaf_pkg::MODE_16: begin
				if (&bankMatch[1:0]) begin
					accepted = 1'b1;
				end else if (&bankMatch[3:2] && rxExtended) begin
					accepted = 1'b1;
					hitIdx = 3'h1;
				end
			end
			ctfaf_pkg::MODE_8: begin
				for (int j = 3; j >= 0; j--) begin
					if (bankMatch[j] && (rxExtended || j < 2)) begin
						accepted = 1'b1;
						hitIdx = 3'(j);
					end
				end
			end
			default: accepted = 1'b0;
		endcase
	end

	// ==========================================================
	// bus decode and next state
	assign access = psel && penable;
	assign wr = access && pwrite;
	// abort granted while idle in queue or after a failed attempt
	assign grant = st.abort_request & ~st.tx_buffer_empty & (txIdle | txFailed);

	always_comb begin
		next_st = st;
		next_st.ready = psel && !st.ready;
		if (wr && paddr == ctfaf_pkg::ADDR_CTRL0) begin
			next_st.ctrl0 = {6'h00, pwdata[1:0]};
		end
		if (wr && paddr == ctfaf_pkg::ADDR_RIE) begin
			next_st.rie = pwdata[7:0];
		end
		if (wr && paddr == ctfaf_pkg::ADDR_TFLG) begin
			next_st.tx_buffer_empty = st.tx_buffer_empty & ~pwdata[2:0];
			next_st.abort_acknowledge = st.abort_acknowledge & ~pwdata[2:0];
		end
		if (wr && paddr == ctfaf_pkg::ADDR_TCTL) begin
			next_st.abort_request = st.abort_request | (pwdata[6:4] & ~st.tx_buffer_empty);
			next_st.tx_empty_irq_enable = pwdata[2:0];
		end
		if (wr && st.ctrl0[ctfaf_pkg::BIT_SRST]) begin
			if (paddr == ctfaf_pkg::ADDR_AFC) begin
				next_st.mode = pwdata[6:4];
			end
			for (int k = 0; k < 4; k++) begin
				if (paddr == ctfaf_pkg::ADDR_CODE0 + 8'(4*k)) begin
					next_st.code[8*k +: 8] = pwdata[7:0];
				end
				if (paddr == ctfaf_pkg::ADDR_MASK0 + 8'(4*k)) begin
					next_st.mask[8*k +: 8] = pwdata[7:0];
				end
			end
		end
		// device sets win over cpu clears
		next_st.tx_buffer_empty = next_st.tx_buffer_empty | txSent | grant;
		next_st.abort_acknowledge = next_st.abort_acknowledge | grant;
		next_st.abort_request = next_st.abort_request & ~next_st.tx_buffer_empty;
		if (rxRelease) begin
			next_st.rxFull = 1'b0;
		end
		// full foreground blocks the copy, message stays dropped
		if (rxDone && accepted && !st.rxFull) begin
			next_st.rxFull = 1'b1;
			next_st.hit = hitIdx;
		end
		if (st.ctrl0[ctfaf_pkg::BIT_SRST]) begin
			next_st.rie = ctfaf_pkg::RST_RIE;
			next_st.tx_buffer_empty = ctfaf_pkg::RST_TFLG[2:0];
			next_st.abort_acknowledge = 3'h0;
			next_st.abort_request = 3'h0;
			next_st.tx_empty_irq_enable = ctfaf_pkg::RST_TCTL[2:0];
			next_st.rxFull = 1'b0;
		end
		next_st.errIrq = (next_st.rie[ctfaf_pkg::BIT_BUS_OFF_IRQ_ENABLE] && busOffFlag)
			|| (next_st.rie[ctfaf_pkg::BIT_OVERRUN_IRQ_ENABLE] && overrunFlag);
		next_st.rxIrq = next_st.rie[ctfaf_pkg::BIT_RX_FULL_IRQ_ENABLE]
			&& next_st.rxFull;
		next_st.txIrq = |(next_st.tx_buffer_empty & next_st.tx_empty_irq_enable);
		next_st.rdata = 32'h0000_0000;
		case (paddr)
			ctfaf_pkg::ADDR_CTRL0: next_st.rdata[7:0] = st.ctrl0;
			ctfaf_pkg::ADDR_RIE: next_st.rdata[7:0] = st.rie;
			ctfaf_pkg::ADDR_TFLG: next_st.rdata[7:0] = {1'b0, st.abort_acknowledge,
				1'b0, st.tx_buffer_empty};
			ctfaf_pkg::ADDR_TCTL: next_st.rdata[7:0] = {1'b0, st.abort_request,
				1'b0, st.tx_empty_irq_enable};
			ctfaf_pkg::ADDR_AFC: next_st.rdata[7:0] = {1'b0, st.mode,
				1'b0, st.hit};
			ctfaf_pkg::ADDR_REC: next_st.rdata[7:0] = recCount;
			ctfaf_pkg::ADDR_TEC: next_st.rdata[7:0] = tecCount;
			ctfaf_pkg::ADDR_STAT: next_st.rdata[0] = st.rxFull;
			default: begin
				for (int m = 0; m < 4; m++) begin
					if (paddr == ctfaf_pkg::ADDR_CODE0 + 8'(4*m)) begin
						next_st.rdata[7:0] = st.code[8*m +: 8];
					end
					if (paddr == ctfaf_pkg::ADDR_MASK0 + 8'(4*m)) begin
						next_st.rdata[7:0] = st.mask[8*m +: 8];
					end
				end
			end
		endcase
	end

	// ==========================================================
	// state register
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			st <= '0;
			st.ctrl0 <= ctfaf_pkg::RST_CTRL0;
			st.tx_buffer_empty <= ctfaf_pkg::RST_TFLG[2:0];
			st.mode <= ctfaf_pkg::MODE_CLOSED;
			st.mask <= 32'hFFFF_FFFF;
		end else begin
			st <= next_st;
		end
	end

	always_comb begin
		prdata = st.rdata;
		pready = st.ready;
		pslverr = 1'b0;
		txSchedule = ~st.tx_buffer_empty;
		abortPending = st.abort_request;
		softReset = st.ctrl0[ctfaf_pkg::BIT_SRST];
		errIrq = st.errIrq;
		rxIrq = st.rxIrq;
		txIrq = st.txIrq;
	end

	// ==========================================================
	// assertions
	property p_txirq;
		@(posedge core_clk) disable iff (!rstn)
		txIrq |-> $past(|(next_st.tx_buffer_empty & next_st.tx_empty_irq_enable));
	endproperty
	a_txirq: assert property (p_txirq) else $error("tx irq bad");

	property p_sent;
		@(posedge core_clk) disable iff (!rstn)
		txSent[0] |=> st.tx_buffer_empty[0];
	endproperty
	a_sent: assert property (p_sent) else $error("txe not set");

	property p_abtclr;
		@(posedge core_clk) disable iff (!rstn)
		st.tx_buffer_empty[0] |-> !st.abort_request[0];
	endproperty
	a_abtclr: assert property (p_abtclr) else $error("abort_request with txe");

	property p_grant;
		@(posedge core_clk) disable iff (!rstn)
		$rose(st.abort_acknowledge[1]) |-> st.tx_buffer_empty[1];
	endproperty
	a_grant: assert property (p_grant) else $error("ack without empty");

	property p_abort_acknowledge;
		@(posedge core_clk) disable iff (!rstn)
		$fell(st.tx_buffer_empty[2]) |-> !st.abort_acknowledge[2];
	endproperty
	a_abort_acknowledge: assert property (p_abort_acknowledge) else $error("ack kept");

	property p_srst;
		@(posedge core_clk) disable iff (!rstn)
		$past(softReset) && softReset |-> st.rie == 8'h00 && st.tx_buffer_empty == 3'h7;
	endproperty
	a_srst: assert property (p_srst) else $error("softreset hold");

	property p_modelock;
		@(posedge core_clk) disable iff (!rstn)
		!softReset |=> $stable(st.mode) && $stable(st.code);
	endproperty
	a_modelock: assert property (p_modelock) else $error("filter changed");

	property p_closed;
		@(posedge core_clk) disable iff (!rstn)
		st.mode == ctfaf_pkg::MODE_CLOSED && !st.rxFull |=> !st.rxFull;
	endproperty
	a_closed: assert property (p_closed) else $error("closed accepted");

	property p_rxirq;
		@(posedge core_clk) disable iff (!rstn)
		rxIrq |-> st.rxFull && st.rie[0];
	endproperty
	a_rxirq: assert property (p_rxirq) else $error("rx irq bad");

	property p_nocpuclr;
		@(posedge core_clk) disable iff (!rstn)
		$fell(st.abort_request[0]) && !$past(softReset) |-> st.tx_buffer_empty[0];
	endproperty
	a_nocpuclr: assert property (p_nocpuclr) else $error("abort_request cleared");

	property p_errirq;
		@(posedge core_clk) disable iff (!rstn)
		errIrq |-> $past(busOffFlag || overrunFlag);
	endproperty
	a_errirq: assert property (p_errirq) else $error("err irq no src");

	property p_errmask;
		@(posedge core_clk) disable iff (!rstn)
		errIrq |-> st.rie[ctfaf_pkg::BIT_BUS_OFF_IRQ_ENABLE] || st.rie[ctfaf_pkg::BIT_OVERRUN_IRQ_ENABLE];
	endproperty
	a_errmask: assert property (p_errmask) else $error("err irq masked");

	property p_rxirqset;
		@(posedge core_clk) disable iff (!rstn)
		st.rxFull && st.rie[ctfaf_pkg::BIT_RX_FULL_IRQ_ENABLE] |-> rxIrq;
	endproperty
	a_rxirqset: assert property (p_rxirqset) else $error("rx irq lost");

	property p_txirqset;
		@(posedge core_clk) disable iff (!rstn)
		|(st.tx_buffer_empty & st.tx_empty_irq_enable) |-> txIrq;
	endproperty
	a_txirqset: assert property (p_txirqset) else $error("tx irq lost");

	property p_txirqmask;
		@(posedge core_clk) disable iff (!rstn)
		txIrq |-> |(st.tx_buffer_empty & st.tx_empty_irq_enable);
	endproperty
	a_txirqmask: assert property (p_txirqmask) else $error("tx irq masked");

	// ack only ever comes from a granted request
	property p_abtakro;
		@(posedge core_clk) disable iff (!rstn)
		$rose(st.abort_acknowledge[0]) |-> $past(st.abort_request[0]);
	endproperty
	a_abtakro: assert property (p_abtakro) else $error("ack not granted");

	property p_hitkeep;
		@(posedge core_clk) disable iff (!rstn)
		!$past(rxDone) |-> $stable(st.hit);
	endproperty
	a_hitkeep: assert property (p_hitkeep) else $error("hit moved");

	property p_rxfullset;
		@(posedge core_clk) disable iff (!rstn)
		rxDone && accepted && !st.rxFull && !softReset |=> st.rxFull;
	endproperty
	a_rxfullset: assert property (p_rxfullset) else $error("rx not full");

	property p_closednohit;
		@(posedge core_clk) disable iff (!rstn)
		st.mode == ctfaf_pkg::MODE_CLOSED |-> !accepted;
	endproperty
	a_closednohit: assert property (p_closednohit) else $error("closed hit");

	property p_maskhold;
		@(posedge core_clk) disable iff (!rstn)
		!softReset |=> $stable(st.mask);
	endproperty
	a_maskhold: assert property (p_maskhold) else $error("mask changed");

	property p_srstabt;
		@(posedge core_clk) disable iff (!rstn)
		$past(softReset) && softReset |-> st.abort_request == 3'h0 && st.tx_empty_irq_enable == 3'h0;
	endproperty
	a_srstabt: assert property (p_srstabt) else $error("tctl not held");

	property p_abtrqset;
		@(posedge core_clk) disable iff (!rstn)
		$rose(st.abort_request[1]) |-> !st.tx_buffer_empty[1];
	endproperty
	a_abtrqset: assert property (p_abtrqset) else $error("abort on empty");

	c_abort: cover property (@(posedge core_clk) $rose(st.abort_acknowledge[0]));
	c_rx: cover property (@(posedge core_clk) $rose(st.rxFull));
	c_hit3: cover property (@(posedge core_clk) st.hit == 3'h3);
	c_tx: cover property (@(posedge core_clk) $rose(txIrq));
endmodule

// ===== ctfaf_pkg.sv
// Purpose: constants for the transmit flag and acceptance filter block
// Assumes: APB with 32-bit data, one register per aligned word
// Notes: byte addresses of the registers are given here; code and mask bytes 1-3 follow CODE0/MASK0 at 4-byte steps
package ctfaf_pkg;
	localparam logic [7:0] ADDR_CTRL0 = 8'h00;
	localparam logic [7:0] ADDR_RIE = 8'h04;
	localparam logic [7:0] ADDR_TFLG = 8'h08;
	localparam logic [7:0] ADDR_TCTL = 8'h0C;
	localparam logic [7:0] ADDR_AFC = 8'h10;
	localparam logic [7:0] ADDR_REC = 8'h14;
	localparam logic [7:0] ADDR_TEC = 8'h18;
	localparam logic [7:0] ADDR_CODE0 = 8'h20;
	localparam logic [7:0] ADDR_MASK0 = 8'h30;
	localparam logic [7:0] ADDR_STAT = 8'h40;
	localparam int BIT_SRST = 0;
	localparam int BIT_SLEEP = 1;
	localparam int BIT_BUS_OFF_IRQ_ENABLE = 3;
	localparam int BIT_OVERRUN_IRQ_ENABLE = 1;
	localparam int BIT_RX_FULL_IRQ_ENABLE = 0;
	localparam int POS_ABORT_ACKNOWLEDGE = 4;
	localparam int POS_TXE = 0;
	localparam int POS_HIT = 4;
	localparam logic [7:0] RST_CTRL0 = 8'h01;
	localparam logic [7:0] RST_RIE = 8'h00;
	localparam logic [7:0] RST_TFLG = 8'h07;
	localparam logic [7:0] RST_TCTL = 8'h00;
	localparam logic [2:0] MODE_32 = 3'h0;
	localparam logic [2:0] MODE_16 = 3'h1;
	localparam logic [2:0] MODE_8 = 3'h2;
	localparam logic [2:0] MODE_CLOSED = 3'h3;
endpackage

// ===== ctfaf_can_model.sv
// Purpose: behavioural can engine on the far side of the filter block
// Assumes: events are one-cycle pulses launched after a rising edge
// Notes: bench sets txIdle and busOffFlag directly
`timescale 1ns/1ns
module ctfaf_can_model (
	input wire logic core_clk,
	output logic busOffFlag,
	output logic overrunFlag,
	output logic rxDone,
	output logic [31:0] rxId,
	output logic rxExtended,
	output logic [2:0] txSent,
	output logic [2:0] txIdle,
	output logic [2:0] txFailed,
	output logic [7:0] recCount,
	output logic [7:0] tecCount
);
	initial begin
		busOffFlag = 1'h0;
		overrunFlag = 1'h0;
		rxDone = 1'h0;
		rxId = 32'h0;
		rxExtended = 1'h0;
		txSent = 3'h0;
		txIdle = 3'h7;
		txFailed = 3'h0;
		recCount = 8'h5A;
		tecCount = 8'hA5;
	end
	// =====================
	// frame events
	task automatic receive(input logic [31:0] id);
		@(posedge core_clk);
		rxDone <= 1'h1;
		rxId <= id;
		rxExtended <= 1'h1;
		@(posedge core_clk);
		rxDone <= 1'h0;
		rxId <= ~id; // stale id must never look valid
		rxExtended <= 1'h0;
	endtask
	task automatic txEnd(input logic [2:0] ok, input logic [2:0] bad);
		@(posedge core_clk);
		txSent <= ok;
		txFailed <= bad;
		@(posedge core_clk);
		txSent <= 3'h0;
		txFailed <= 3'h0;
	endtask
endmodule

// ===== tb.sv
// Purpose: apb bench for tx flags, abort handshake and filter
// Assumes: slave answers well inside 20 cycles
// Notes: only extended ids are sent, so mask 1 low bits stay free
`timescale 1ns/1ns
module tb;
	logic core_clk, rstn, psel, penable, pwrite, rxRelease;
	logic [7:0] paddr, recCount, tecCount;
	logic [31:0] pwdata, prdata, rxId;
	logic pready, pslverr, busOffFlag, overrunFlag, rxDone, rxExtended;
	logic errIrq, rxIrq, txIrq, softReset;
	logic [2:0] txSent, txIdle, txFailed, txSchedule, abortPending;
	int fail_count = 0;
	int check_count = 0;
	ctfaf_top u_dut (.core_clk, .rstn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .busOffFlag, .overrunFlag,
		.rxDone, .rxId, .rxExtended, .rxRelease, .txSent, .txIdle,
		.txFailed, .recCount, .tecCount, .txSchedule, .abortPending,
		.softReset, .errIrq, .rxIrq, .txIrq);
	ctfaf_can_model u_can (.core_clk, .busOffFlag, .overrunFlag, .rxDone,
		.rxId, .rxExtended, .txSent, .txIdle, .txFailed, .recCount,
		.tecCount);
	initial begin
		core_clk = 1'h0;
		forever #20 core_clk = ~core_clk;
	end
	// =====================
	// tasks
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			fail_count++;
			$display("Error %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] r);
		int n;
		n = 0;
		@(posedge core_clk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'h1;
		do begin
			@(posedge core_clk);
			n++;
		end while (pready !== 1'h1 && n < 20);
		if (n >= 20) begin
			fail_count++;
			test_done();
		end
		r = prdata;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		apb(1'h1, a, d, r);
		// registered outputs settle one edge after the write lands
		@(posedge core_clk);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] r;
		apb(1'h0, a, 32'h0, r);
		chk(r, e);
	endtask
	task automatic test_done;
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	initial begin
		#200000;
		fail_count++;
		test_done();
	end
	// =====================
	// tests
	initial begin
		rstn = 1'h0;
		psel = 1'h0;
		penable = 1'h0;
		pwrite = 1'h0;
		paddr = 8'h0;
		pwdata = 32'h0;
		rxRelease = 1'h0;
		repeat (3) @(posedge core_clk);
		rstn <= 1'h1;
		rd(ctfaf_pkg::ADDR_TFLG, 32'h07);
		rd(ctfaf_pkg::ADDR_AFC, 32'h30);
		rd(ctfaf_pkg::ADDR_MASK0, 32'hFF);
		wr(ctfaf_pkg::ADDR_CTRL0, 32'h0);
		wr(ctfaf_pkg::ADDR_RIE, 32'h1);
		u_can.receive(32'h33221100);
		repeat (3) @(posedge core_clk);
		chk({31'h0, rxIrq}, 32'h0);
		wr(ctfaf_pkg::ADDR_AFC, 32'h0);
		rd(ctfaf_pkg::ADDR_AFC, 32'h30);
		wr(ctfaf_pkg::ADDR_CODE0, 32'h55);
		rd(ctfaf_pkg::ADDR_CODE0, 32'h0);
		wr(ctfaf_pkg::ADDR_CTRL0, 32'h1);
		rd(ctfaf_pkg::ADDR_RIE, 32'h0);
		wr(ctfaf_pkg::ADDR_AFC, 32'h0);
		for (logic [7:0] k = 8'h0; k < 8'h4; k++) begin
			wr(ctfaf_pkg::ADDR_CODE0 + 8'h4 * k, {24'h0, 8'h11 * k});
			wr(ctfaf_pkg::ADDR_MASK0 + 8'h4 * k, 32'h0);
		end
		wr(ctfaf_pkg::ADDR_CTRL0, 32'h0);
		wr(ctfaf_pkg::ADDR_RIE, 32'h1);
		u_can.receive(32'h33221100);
		repeat (3) @(posedge core_clk);
		chk({31'h0, rxIrq}, 32'h1);
		rd(ctfaf_pkg::ADDR_STAT, 32'h1);
		rd(ctfaf_pkg::ADDR_AFC, 32'h0);
		@(posedge core_clk);
		rxRelease <= 1'h1;
		@(posedge core_clk);
		rxRelease <= 1'h0;
		u_can.receive(32'h33221101);
		rd(ctfaf_pkg::ADDR_STAT, 32'h0);
		chk({31'h0, rxIrq}, 32'h0);
		wr(ctfaf_pkg::ADDR_TCTL, 32'h1);
		chk({31'h0, txIrq}, 32'h1);
		wr(ctfaf_pkg::ADDR_TFLG, 32'h1);
		chk({29'h0, txSchedule}, 32'h1);
		chk({31'h0, txIrq}, 32'h0);
		wr(ctfaf_pkg::ADDR_TFLG, 32'h0);
		rd(ctfaf_pkg::ADDR_TFLG, 32'h06);
		u_can.txEnd(3'h1, 3'h0);
		rd(ctfaf_pkg::ADDR_TFLG, 32'h07);
		// clear and abort in separate accesses
		wr(ctfaf_pkg::ADDR_TFLG, 32'h2);
		wr(ctfaf_pkg::ADDR_TCTL, 32'h21);
		rd(ctfaf_pkg::ADDR_TFLG, 32'h27);
		rd(ctfaf_pkg::ADDR_TCTL, 32'h01);
		wr(ctfaf_pkg::ADDR_TFLG, 32'h2);
		rd(ctfaf_pkg::ADDR_TFLG, 32'h05);
		u_can.txEnd(3'h2, 3'h0);
		u_can.txIdle <= 3'h3;
		wr(ctfaf_pkg::ADDR_TFLG, 32'h4);
		wr(ctfaf_pkg::ADDR_TCTL, 32'h41);
		wr(ctfaf_pkg::ADDR_TCTL, 32'h01);
		rd(ctfaf_pkg::ADDR_TCTL, 32'h41);
		chk({29'h0, abortPending}, 32'h4);
		u_can.txEnd(3'h0, 3'h4);
		rd(ctfaf_pkg::ADDR_TFLG, 32'h47);
		rd(ctfaf_pkg::ADDR_TCTL, 32'h01);
		wr(ctfaf_pkg::ADDR_RIE, 32'h8);
		u_can.busOffFlag <= 1'h1;
		rd(ctfaf_pkg::ADDR_REC, 32'h5A);
		chk({31'h0, errIrq}, 32'h1);
		wr(ctfaf_pkg::ADDR_RIE, 32'h0);
		chk({31'h0, errIrq}, 32'h0);
		rd(ctfaf_pkg::ADDR_TEC, 32'hA5);
		rd(8'h44, 32'h0);
		chk({31'h0, pslverr}, 32'h0);
		chk({31'h0, softReset}, 32'h0);
		wr(ctfaf_pkg::ADDR_CTRL0, 32'h1);
		rd(ctfaf_pkg::ADDR_TCTL, 32'h0);
		// four 8-bit filters: lowest matching bank wins
		wr(ctfaf_pkg::ADDR_AFC, 32'h20);
		wr(ctfaf_pkg::ADDR_CTRL0, 32'h0);
		u_can.receive(32'h332211FF);
		rd(ctfaf_pkg::ADDR_AFC, 32'h21);
		// two 16-bit filters: upper half hits
		wr(ctfaf_pkg::ADDR_CTRL0, 32'h1);
		wr(ctfaf_pkg::ADDR_AFC, 32'h10);
		wr(ctfaf_pkg::ADDR_CTRL0, 32'h0);
		u_can.receive(32'h3322FFFF);
		rd(ctfaf_pkg::ADDR_AFC, 32'h11);
		test_done();
	end
endmodule
